//--- pkg/pin_ctrl_pkg.sv
package pin_ctrl_pkg;

  // core clock rate and pulse timing
  localparam int unsigned CORE_CLK_MHZ     = 250;
  localparam int unsigned MIN_PULSE_MS     = 20;
  localparam int unsigned MIN_PULSE_CYCLES = MIN_PULSE_MS * 1000 * CORE_CLK_MHZ;
  localparam int unsigned DEBOUNCE_CYCLES  = 1024;
  localparam int unsigned RESET_DELAY_CYCLES = 4096;
  localparam int unsigned CNT_W            = 24;

  // configuration bit positions
  localparam int unsigned CFG_INT_EN_BIT   = 1;
  localparam int unsigned CFG_RST_OUT_BIT  = 4;
  localparam int unsigned CFG_CHS_CLR_BIT  = 6;

  // serial address layout
  localparam logic [4:0] ADDR_UPPER_DEFAULT = 5'h0B;
  localparam logic [6:0] ADDR_RESET_VALUE   = 7'h2C;

  // processor voltage-code layout and reserved fill
  localparam logic [3:0] VCODE_LOW_FILL  = 4'h5;
  localparam logic [6:0] VCODE_HIGH_FILL = 7'h40;

  // open-drain pin as two signals
  typedef struct packed {
    logic drive_low;
    logic oe;
  } od_pin_type;

  // readable status toward the register side
  typedef struct packed {
    logic [7:0] vcode_low;
    logic [7:0] vcode_high;
    logic [6:0] bus_addr;
    logic       chs_level;
    logic       test_mode;
  } pin_status_type;

endpackage

//--- src/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_stage2;

  // two-flop chain, first stage read only by the second
  always_comb begin
    next_stage1 = i_async;
    next_stage2 = stage1;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign o_sync = stage2;
endmodule

//--- src/pulse_timer.sv
`timescale 1ns/1ps
module pulse_timer (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_start,
  output logic                              o_busy
);
  logic [pin_ctrl_pkg::CNT_W-1:0] count;
  logic [pin_ctrl_pkg::CNT_W-1:0] next_count;
  logic                           busy;
  logic                           next_busy;

  // counts a minimum-length low pulse; retrigger while busy is ignored
  always_comb begin
    next_count = count;
    next_busy  = busy;
    if (!busy && i_start) begin
      next_busy  = 1'b1;
      next_count = pin_ctrl_pkg::CNT_W'(pin_ctrl_pkg::MIN_PULSE_CYCLES - 1); // RULE_18
    end else if (busy) begin
      if (count == '0) begin
        next_busy = 1'b0;
      end else begin
        next_count = count - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count <= '0;
      busy  <= 1'b0;
    end else begin
      count <= next_count;
      busy  <= next_busy;
    end
  end

  assign o_busy = busy;
endmodule

//--- src/monitor_system_pin_control.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01: address low bits from the two pins
// RULE_02: test mode turns low address pin output
// RULE_03: high shared pin enters chain test
// RULE_04: otherwise shared pin is fan converter output
// RULE_05: intrusion latch drives active high level
// RULE_06: config bit 6 pulls intrusion pin low
// RULE_07: interrupt drives low only when bit 1
// RULE_08: config bit 4 pulses reset pin low
// RULE_09: reset pin also a power-on reset input
// RULE_10: remote reset debounced, delayed, restores defaults
// RULE_11: voltage-code pins readable in two registers
// RULE_12: interrupt fires on any out-of-range quantity
// RULE_13: power-on address is fixed pattern plus pins
// RULE_14: host address write keeps two low bits
// RULE_15: host write sends address, pointer, data
// RULE_16: host read uses pointer then restart read
// RULE_17: reset input accepted after stable low count
// RULE_18: pulse lengths counted from system clock
module monitor_system_pin_control #(
  parameter int unsigned DEBOUNCE_CYCLES    = pin_ctrl_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned RESET_DELAY_CYCLES = pin_ctrl_pkg::RESET_DELAY_CYCLES
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_scl_clk,
  input  wire logic                        i_address_pin_low,
  input  wire logic                        i_address_pin_high,
  input  wire logic                        i_fan_dac_or_test_enable,
  input  wire logic                        i_chassis_intrusion_pin,
  input  wire logic                        i_reset_pin,
  input  wire logic [4:0]                  i_processor_voltage_code,
  input  wire logic [7:0]                  i_config,
  input  wire logic                        i_chs_clear_req,
  input  wire logic                        i_addr_wr,
  input  wire logic [4:0]                  i_addr_wr_upper,
  input  wire logic                        i_limit_violation,
  input  wire logic [7:0]                  i_chain_in,
  output logic                             o_address_pin_low_out,
  output logic                             o_address_pin_low_oe,
  output logic                             o_fan_dac_enable,
  output logic                             o_chs_drive_low,
  output logic                             o_chs_oe,
  output logic                             o_int_n,
  output logic                             o_int_oe,
  output logic                             o_reset_drive_low,
  output logic                             o_reset_oe,
  output logic                             o_soft_reset,
  output logic [6:0]                       o_bus_addr_link,
  output pin_ctrl_pkg::pin_status_type     o_status
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] addr_pins;
  logic       test_en;
  logic       chs_sync;
  logic       rst_pin_sync;
  logic [4:0] vcode_sync;

  sync2 #(.W(2)) u_sync_addr (
    .i_clk   (i_core_clk),
    .i_rst   (i_sys_rst),
    .i_async ({i_address_pin_high, i_address_pin_low}),
    .o_sync  (addr_pins)
  );

  sync2 #(.W(1)) u_sync_test (
    .i_clk   (i_core_clk),
    .i_rst   (i_sys_rst),
    .i_async (i_fan_dac_or_test_enable),
    .o_sync  (test_en)
  );

  sync2 #(.W(1)) u_sync_chs (
    .i_clk   (i_core_clk),
    .i_rst   (i_sys_rst),
    .i_async (i_chassis_intrusion_pin),
    .o_sync  (chs_sync)
  );

  sync2 #(.W(5)) u_sync_vcode (
    .i_clk   (i_core_clk),
    .i_rst   (i_sys_rst),
    .i_async (i_processor_voltage_code),
    .o_sync  (vcode_sync)
  );

  // reset pin idles high, so its synchroniser resets to one via inversion
  logic rst_pin_low_sync;

  sync2 #(.W(1)) u_sync_rstpin (
    .i_clk   (i_core_clk),
    .i_rst   (i_sys_rst),
    .i_async (~i_reset_pin),
    .o_sync  (rst_pin_low_sync)
  );

  assign rst_pin_sync = ~rst_pin_low_sync;

  ////////////////////////////////////////////////////////////////////////////
  // remote reset: debounce, delay, then soft reset

  typedef enum logic [1:0] {
    RR_IDLE,
    RR_DEBOUNCE,
    RR_DELAY,
    RR_ASSERT
  } rr_state_type;

  rr_state_type rr_state;
  rr_state_type next_rr_state;
  logic [31:0]  rr_count;
  logic [31:0]  next_rr_count;
  logic         soft_reset;
  logic         next_soft_reset;
  logic         own_reset_busy;
  logic [2:0]   own_busy_hist;
  logic [2:0]   next_own_busy_hist;

  always_comb begin
    next_rr_state      = rr_state;
    next_rr_count      = rr_count;
    next_soft_reset    = 1'b0;
    next_own_busy_hist = {own_busy_hist[1:0], own_reset_busy}; // covers pin readback lag
    case (rr_state)
      RR_IDLE: begin
        // own pulse reads back low; do not reset ourselves from it
        if (!rst_pin_sync && !own_reset_busy && !(|own_busy_hist)) begin // RULE_09
          next_rr_state = RR_DEBOUNCE;
          next_rr_count = '0;
        end
      end
      RR_DEBOUNCE: begin
        if (rst_pin_sync) begin
          next_rr_state = RR_IDLE;
        end else if (rr_count >= DEBOUNCE_CYCLES - 1) begin // RULE_17
          next_rr_state = RR_DELAY;
          next_rr_count = '0;
        end else begin
          next_rr_count = rr_count + 32'h00000001;
        end
      end
      RR_DELAY: begin
        if (rr_count >= RESET_DELAY_CYCLES - 1) begin // RULE_10
          next_rr_state   = RR_ASSERT;
          next_soft_reset = 1'b1;
        end else begin
          next_rr_count = rr_count + 32'h00000001;
        end
      end
      RR_ASSERT: begin
        // wait for release so one press gives one reset
        if (rst_pin_sync) begin
          next_rr_state = RR_IDLE;
        end
      end
      default: begin
        next_rr_state = RR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rr_state      <= RR_IDLE;
      rr_count      <= '0;
      soft_reset    <= 1'b0;
      own_busy_hist <= 3'h0;
    end else begin
      rr_state      <= next_rr_state;
      rr_count      <= next_rr_count;
      soft_reset    <= next_soft_reset;
      own_busy_hist <= next_own_busy_hist;
    end
  end

  logic local_rst;
  assign local_rst = i_sys_rst | soft_reset; // RULE_10

  ////////////////////////////////////////////////////////////////////////////
  // open-drain pulse timers

  logic chs_start;
  logic chs_busy;
  logic rst_start;

  assign chs_start = i_chs_clear_req & i_config[pin_ctrl_pkg::CFG_CHS_CLR_BIT]; // RULE_06
  assign rst_start = i_config[pin_ctrl_pkg::CFG_RST_OUT_BIT] & ~own_reset_busy; // RULE_08

  pulse_timer u_chs_timer (
    .i_clk   (i_core_clk),
    .i_rst   (local_rst),
    .i_start (chs_start),
    .o_busy  (chs_busy)
  );

  pulse_timer u_rst_timer (
    .i_clk   (i_core_clk),
    .i_rst   (local_rst),
    .i_start (rst_start),
    .o_busy  (own_reset_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial address register

  logic [4:0] addr_upper;
  logic [4:0] next_addr_upper;
  logic [6:0] bus_addr;

  // host writes replace only the upper bits
  always_comb begin
    next_addr_upper = addr_upper;
    if (i_addr_wr) begin
      next_addr_upper = i_addr_wr_upper; // RULE_14
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (local_rst) begin
      addr_upper <= pin_ctrl_pkg::ADDR_UPPER_DEFAULT; // RULE_13
    end else begin
      addr_upper <= next_addr_upper;
    end
  end

  // both pin bits frozen at their last input value during test mode
  logic [1:0] addr_low;
  logic [1:0] next_addr_low;

  always_comb begin
    next_addr_low = addr_low;
    if (!test_en) begin
      next_addr_low = addr_pins; // RULE_01
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (local_rst) begin
      addr_low <= 2'h0;
    end else begin
      addr_low <= next_addr_low;
    end
  end

  assign bus_addr = {addr_upper, addr_low}; // RULE_13

  ////////////////////////////////////////////////////////////////////////////
  // address crossing into the serial clock domain

  logic [6:0] scl_addr_s1;
  logic [6:0] scl_addr_s2;
  logic [6:0] next_scl_addr_s1;
  logic [6:0] next_scl_addr_s2;
  logic [6:0] scl_addr_s3;
  logic [6:0] scl_addr_held;
  logic [6:0] next_scl_addr_s3;
  logic [6:0] next_scl_addr_held;

  // quasi-static word; taken only once two synced samples agree, so no torn value
  always_comb begin
    next_scl_addr_s1   = bus_addr;
    next_scl_addr_s2   = scl_addr_s1;
    next_scl_addr_s3   = scl_addr_s2;
    next_scl_addr_held = (scl_addr_s3 == scl_addr_s2) ? scl_addr_s2 : scl_addr_held;
  end

  always_ff @(posedge i_scl_clk) begin
    scl_addr_s1   <= next_scl_addr_s1;
    scl_addr_s2   <= next_scl_addr_s2;
    scl_addr_s3   <= next_scl_addr_s3;
    scl_addr_held <= next_scl_addr_held;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered pin outputs and status

  logic                         chain_out;
  pin_ctrl_pkg::pin_status_type next_status;

  assign chain_out = ~&i_chain_in;

  always_comb begin
    next_status.vcode_low  = {pin_ctrl_pkg::VCODE_LOW_FILL, vcode_sync[3:0]}; // RULE_11
    next_status.vcode_high = {pin_ctrl_pkg::VCODE_HIGH_FILL, vcode_sync[4]};  // RULE_11
    next_status.bus_addr   = bus_addr;
    next_status.chs_level  = chs_sync;
    next_status.test_mode  = test_en;
  end

  always_ff @(posedge i_core_clk) begin
    if (local_rst) begin
      o_address_pin_low_out <= 1'b0;
      o_address_pin_low_oe  <= 1'b0;
      o_fan_dac_enable      <= 1'b0;
      o_chs_drive_low       <= 1'b0;
      o_chs_oe              <= 1'b0;
      o_int_n               <= 1'b1;
      o_int_oe              <= 1'b0;
      o_reset_drive_low     <= 1'b0;
      o_reset_oe            <= 1'b0;
      o_status              <= '0;
    end else begin
      o_address_pin_low_out <= test_en & chain_out; // RULE_02
      o_address_pin_low_oe  <= test_en;             // RULE_03
      o_fan_dac_enable      <= ~test_en;            // RULE_04
      o_chs_drive_low       <= chs_busy;            // RULE_06
      o_chs_oe              <= chs_busy;
      o_int_n               <= ~(i_config[pin_ctrl_pkg::CFG_INT_EN_BIT] & i_limit_violation); // RULE_12
      o_int_oe              <= i_config[pin_ctrl_pkg::CFG_INT_EN_BIT] & i_limit_violation;    // RULE_07
      o_reset_drive_low     <= own_reset_busy;      // RULE_08
      o_reset_oe            <= own_reset_busy;
      o_status              <= next_status;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_soft_reset <= 1'b0;
    end else begin
      o_soft_reset <= soft_reset;
    end
  end

  assign o_bus_addr_link = scl_addr_held;

endmodule

//--- sim/pin_ctrl_assertions.sv
`timescale 1ns/1ps
module pin_ctrl_assertions #(
  parameter int unsigned DEBOUNCE_CYCLES    = 4,
  parameter int unsigned RESET_DELAY_CYCLES = 8
) (
  input wire logic                       i_core_clk,
  input wire logic                       i_sys_rst,
  input wire logic                       i_fan_dac_or_test_enable,
  input wire logic                       i_address_pin_low,
  input wire logic                       i_address_pin_high,
  input wire logic                       i_reset_pin,
  input wire logic [7:0]                 i_config,
  input wire logic                       i_chs_clear_req,
  input wire logic                       i_addr_wr,
  input wire logic [4:0]                 i_addr_wr_upper,
  input wire logic                       i_limit_violation,
  input wire logic [7:0]                 i_chain_in,
  input wire logic                       o_address_pin_low_out,
  input wire logic                       o_address_pin_low_oe,
  input wire logic                       o_fan_dac_enable,
  input wire logic                       o_chs_drive_low,
  input wire logic                       o_chs_oe,
  input wire logic                       o_int_n,
  input wire logic                       o_int_oe,
  input wire logic                       o_reset_drive_low,
  input wire logic                       o_reset_oe,
  input wire logic                       o_soft_reset,
  input wire pin_ctrl_pkg::pin_status_type o_status
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  int unsigned hold_cnt;
  int unsigned low_cnt;
  ////////////////////////////////////////////////////////////////
  // cycles the reset pulse has stood and the reset pin stayed low
  always_ff @(posedge i_core_clk) begin
    hold_cnt <= (i_sys_rst || !o_reset_oe) ? 0 : hold_cnt + 1;
    low_cnt  <= (i_sys_rst || i_reset_pin) ? 0 : low_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////
  a_chain_mode: assert property ((i_fan_dac_or_test_enable && !o_soft_reset)[*6]
    |-> o_address_pin_low_oe && !o_fan_dac_enable) else $error("chain test mode not entered");
  a_fan_mode: assert property ((!i_fan_dac_or_test_enable && !o_soft_reset)[*6]
    |-> !o_address_pin_low_oe && o_fan_dac_enable) else $error("fan output not restored");
  a_chain_value: assert property ((o_address_pin_low_oe && $stable(i_chain_in))[*4]
    |-> o_address_pin_low_out == ~&i_chain_in) else $error("chain result wrong");
  a_int_drive: assert property (!$past(i_sys_rst) && !o_soft_reset
    |-> o_int_oe == $past(i_config[1] && i_limit_violation) && o_int_n == !o_int_oe)
    else $error("interrupt drive wrong");
  a_chs_start: assert property ((!o_chs_oe)[*3] ##0 (i_chs_clear_req && i_config[6])
    |-> ##[1:2] (o_chs_oe && o_chs_drive_low)) else $error("intrusion clear not started");
  a_rst_start: assert property ((!o_reset_oe)[*3] ##0 i_config[4]
    |-> ##[1:2] (o_reset_oe && o_reset_drive_low)) else $error("reset pulse not started");
  a_rst_hold: assert property (o_reset_oe && hold_cnt < pin_ctrl_pkg::MIN_PULSE_CYCLES - 1
    |=> o_reset_oe && o_reset_drive_low) else $error("reset pulse too short");
  a_addr_pins: assert property ((!o_address_pin_low_oe && !o_soft_reset
    && $stable({i_address_pin_high, i_address_pin_low}))[*6]
    |-> o_status.bus_addr[1:0] == {i_address_pin_high, i_address_pin_low}) else $error("address pins lost");
  a_addr_write: assert property (i_addr_wr ##1 $stable(i_addr_wr_upper)[*3]
    |-> o_status.bus_addr[6:2] == i_addr_wr_upper) else $error("address write lost");
  a_debounce_wait: assert property ($rose(o_soft_reset)
    |-> low_cnt >= DEBOUNCE_CYCLES + RESET_DELAY_CYCLES) else $error("remote reset too early");
endmodule

//--- sim/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_go,
  input  wire logic [4:0] i_upper,
  output logic            o_scl_clk,
  output logic            o_addr_wr,
  output logic [4:0]      o_addr_wr_upper,
  output logic            o_busy
);
  // serial clock runs only inside a frame and idles high
  task automatic frame(input int bits);
    #1.7;
    repeat (bits) begin
      #6 o_scl_clk = 1'b0;
      #6 o_scl_clk = 1'b1;
    end
  endtask
  // address write frame, then pointer write and restart read
  initial begin
    o_scl_clk = 1'b1;
    o_addr_wr = 1'b0;
    o_addr_wr_upper = 5'h00;
    o_busy = 1'b0;
    forever begin
      @(posedge i_go);
      o_busy = 1'b1;
      frame(27);
      @(posedge i_core_clk);
      o_addr_wr <= 1'b1;
      o_addr_wr_upper <= i_upper;
      @(posedge i_core_clk);
      o_addr_wr <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      o_addr_wr_upper <= ~i_upper; // released data no longer shows the value
      frame(36);
      o_busy <= 1'b0;
    end
  end
endmodule

//--- sim/monitor_system_pin_control_test.sv
`timescale 1ns/1ps
module monitor_system_pin_control_test;
  localparam int unsigned DEB = 4;
  localparam int unsigned DLY = 8;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_address_pin_high = 1'b1, i_fan_dac_or_test_enable = 1'b0;
  logic i_chs_clear_req = 1'b0, i_limit_violation = 1'b0, a0_drv = 1'b0, chs_latch = 1'b0, ext_rst = 1'b0;
  logic [4:0] i_processor_voltage_code = 5'h00, up = 5'h00;
  logic [7:0] i_config = 8'h00, i_chain_in = 8'h00, note;
  logic go = 1'b0;
  logic o_address_pin_low_out, o_address_pin_low_oe, o_fan_dac_enable, o_chs_drive_low, o_chs_oe;
  logic o_int_n, o_int_oe, o_reset_drive_low, o_reset_oe, o_soft_reset;
  logic [6:0] o_bus_addr_link;
  pin_ctrl_pkg::pin_status_type o_status;
  wire i_scl_clk, i_addr_wr, busy, i_address_pin_low, i_chassis_intrusion_pin, i_reset_pin;
  wire [4:0] i_addr_wr_upper;
  wire [2:0] ev = {o_soft_reset, o_reset_oe, o_chs_oe};
  logic [2:0] ev_prev = 3'h0;
  logic [7:0] note_q[$];
  logic [31:0] r;
  int seed = 56, n, mismatches = 0, n_compared = 0;
  ////////////////////////////////////////////////////////////////
  // wire levels from every driver of the shared pins
  assign i_address_pin_low = o_address_pin_low_oe ? o_address_pin_low_out : a0_drv;
  assign i_chassis_intrusion_pin = chs_latch & !(o_chs_oe & o_chs_drive_low);
  assign i_reset_pin = !ext_rst & !(o_reset_oe & o_reset_drive_low);
  initial forever #2 i_core_clk = ~i_core_clk;
  monitor_system_pin_control #(.DEBOUNCE_CYCLES(DEB), .RESET_DELAY_CYCLES(DLY)) dut (.*);
  host_link_model host (.i_core_clk(i_core_clk), .i_go(go), .i_upper(up), .o_scl_clk(i_scl_clk),
    .o_addr_wr(i_addr_wr), .o_addr_wr_upper(i_addr_wr_upper), .o_busy(busy));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_core_clk);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // each rising event output takes the oldest note
  always @(posedge i_core_clk) begin
    ev_prev <= ev;
    for (int k = 0; k < 3; k++) begin
      if (ev[k] === 1'b1 && ev_prev[k] !== 1'b1) begin
        note = (note_q.size() > 0) ? note_q.pop_front() : 8'hFF;
        chk("event", note, 8'(k));
      end
    end
  end
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    i_sys_rst <= 1'b0;
    cyc(8);
    chk("addr", {1'b0, pin_ctrl_pkg::ADDR_UPPER_DEFAULT, 2'b10}, {1'b0, o_status.bus_addr});
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      i_processor_voltage_code <= r[4:0];
      i_chain_in <= r[12:5];
      i_fan_dac_or_test_enable <= r[13];
      i_config <= {6'h00, r[14], 1'b0};
      i_limit_violation <= r[15];
      cyc(8);
      chk("vlow", {pin_ctrl_pkg::VCODE_LOW_FILL, r[3:0]}, o_status.vcode_low);
      chk("vhigh", {pin_ctrl_pkg::VCODE_HIGH_FILL, r[4]}, o_status.vcode_high);
      chk("mode", {6'h00, r[13], !r[13]}, {6'h00, o_address_pin_low_oe, o_fan_dac_enable});
      if (r[13]) chk("chain", {7'h00, ~&r[12:5]}, {7'h00, o_address_pin_low_out});
      chk("int", {7'h00, !(r[14] & r[15])}, {7'h00, o_int_n});
    end
    i_fan_dac_or_test_enable <= 1'b0;
    i_config <= 8'h00;
    a0_drv <= 1'b1;
    i_address_pin_high <= 1'b0;
    up <= r[20:16];
    go <= 1'b1;
    cyc(2);
    go <= 1'b0;
    for (n = 0; n < 400 && busy === 1'b1; n++) cyc(1);
    chk("host_done", 8'h00, {7'h00, busy});
    cyc(2);
    chk("addr_wr", {1'b0, up, 2'b01}, {1'b0, o_status.bus_addr});
    chk("addr_link", {1'b0, up, 2'b01}, {1'b0, o_bus_addr_link});
    ext_rst <= 1'b1; // short glitch must be filtered
    cyc(2);
    ext_rst <= 1'b0;
    cyc(30);
    note_q.push_back(8'h02);
    ext_rst <= 1'b1;
    for (n = 0; n < 200 && o_soft_reset !== 1'b1; n++) cyc(1);
    chk("delay", 8'h01, {7'h00, n >= DEB + DLY && n < 200});
    ext_rst <= 1'b0;
    cyc(8);
    chk("restore", {1'b0, pin_ctrl_pkg::ADDR_UPPER_DEFAULT, 2'b01}, {1'b0, o_status.bus_addr});
    chs_latch <= 1'b1;
    cyc(8);
    chk("chs_in", 8'h01, {7'h00, o_status.chs_level});
    note_q.push_back(8'h00);
    i_config <= 8'h40;
    i_chs_clear_req <= 1'b1;
    cyc(1);
    i_chs_clear_req <= 1'b0;
    cyc(2000);
    chk("chs_pull", 8'h03, {6'h00, o_chs_oe, o_chs_drive_low});
    chk("chs_in", 8'h00, {7'h00, o_status.chs_level});
    note_q.push_back(8'h01);
    i_config <= 8'h50;
    cyc(2000);
    chk("rst_pull", 8'h03, {6'h00, o_reset_oe, o_reset_drive_low});
    i_sys_rst <= 1'b1;
    cyc(4);
    chk("released", 8'h00, {4'h0, o_chs_oe, o_reset_oe, o_int_oe, o_address_pin_low_oe});
    chk("pending", 8'h00, 8'(note_q.size()));
    summarize();
  end
endmodule
bind monitor_system_pin_control pin_ctrl_assertions #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)) chk_u (.*);
